// >>> digit_stepper.v
// one bcd digit step with optional carry out
// assumes caller presents a one-cycle step pulse
`timescale 1ns/1ps
`include "panel_regs.vh"
module digit_stepper (
  input  wire [3:0] digit_in,
  input  wire       carry_en,
  output reg  [3:0] digit_out,
  output reg        carry_out
);
  always @* begin
    if (digit_in >= `DIGIT_MAX) begin
      digit_out = `DIGIT_ZERO;
      carry_out = carry_en;
    end else begin
      digit_out = digit_in + 4'h1;
      carry_out = 1'b0;
    end
  end
endmodule

// >>> panel_control.v
// front panel modes, output fault response and power-up self-test
// assumes keys, switches and fault sense are asynchronous pins; reset is
// power-up; self-test results come from the processor as level inputs
`timescale 1ns/1ps
`include "panel_regs.vh"
module panel_control #(
  parameter FAULT_DELAY_CYCLES = `FAULT_DELAY_MS * `CLK_KHZ,
  parameter STEP_CYCLES        = 5000000,
  parameter REPEAT_CYCLES      = 5000000
) (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        select_key,
  input  wire        deviation_key,
  input  wire        arrow_kb_key,
  input  wire        arrow_flt_key,
  input  wire        up_key,
  input  wire [1:0]  range_sel,
  input  wire        reselect,
  input  wire        overload_sense,
  input  wire [7:0]  addr_switch,
  input  wire        cal_key,
  input  wire        cal_corrupt,
  input  wire [2:0]  hw_fault_code,
  input  wire        selftest_checks_done,
  input  wire [3:0]  set_digit,
  output reg         fn_display_ff,
  output reg  [1:0]  kb_mode_ff,
  output reg  [2:0]  flt_mode_ff,
  output reg  [3:0]  digit_ff,
  output reg         digit_carry_ff,
  output reg         output_zero_ff,
  output reg         output_fault_indication_ff,
  output reg  [1:0]  range_ff,
  output reg         selftest_ff,
  output reg  [5:0]  seg_lamp_ff,
  output reg         seg_lamp_on_ff,
  output reg  [19:0] led_lamp_ff,
  output reg         pass_word_ff,
  output reg         error_word_ff,
  output reg  [2:0]  error_code_ff,
  output reg         cal_erase_ff,
  output reg  [7:0]  addr_latched_ff
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SEG  = 3'h1;
  localparam ST_LED  = 3'h2;
  localparam ST_WAIT = 3'h3;
  localparam ST_DONE = 3'h4;
  localparam ST_RUN  = 3'h5;

  // two-flop synchronisers for all pin inputs
  reg [8:0]  s1_ff;
  reg [8:0]  s2_ff;
  reg [7:0]  sw1_ff;
  reg [7:0]  sw2_ff;
  reg [1:0]  rg1_ff;
  reg [1:0]  rg2_ff;
  reg        cal1_ff;
  reg        cal2_ff;
  // code and digit are held steady around their strobes
  reg [2:0]  code1_ff;
  reg [2:0]  code2_ff;
  reg [3:0]  dig1_ff;
  reg [3:0]  dig2_ff;
  always @(posedge core_clk) begin
    if (reset) begin
      code1_ff <= `ERR_NONE;
      code2_ff <= `ERR_NONE;
      dig1_ff  <= `DIGIT_ZERO;
      dig2_ff  <= `DIGIT_ZERO;
      s1_ff   <= 9'h0;
      s2_ff   <= 9'h0;
      sw1_ff  <= 8'h0;
      sw2_ff  <= 8'h0;
      rg1_ff  <= 2'h0;
      rg2_ff  <= 2'h0;
      cal1_ff <= 1'b0;
      cal2_ff <= 1'b0;
    end else begin
      s1_ff   <= {cal_corrupt, select_key, deviation_key, arrow_kb_key,
                  arrow_flt_key, up_key, reselect, overload_sense,
                  selftest_checks_done};
      s2_ff   <= s1_ff;
      sw1_ff  <= addr_switch;
      sw2_ff  <= sw1_ff;
      rg1_ff  <= range_sel;
      rg2_ff  <= rg1_ff;
      cal1_ff <= cal_key;
      cal2_ff <= cal1_ff;
      code1_ff <= hw_fault_code;
      code2_ff <= code1_ff;
      dig1_ff  <= set_digit;
      dig2_ff  <= dig1_ff;
    end
  end
  wire cal_bad_s  = s2_ff[8];
  wire sel_s      = s2_ff[7];
  wire dev_s      = s2_ff[6];
  wire akb_s      = s2_ff[5];
  wire aflt_s     = s2_ff[4];
  wire up_s       = s2_ff[3];
  wire resel_s    = s2_ff[2];
  wire ovl_s      = s2_ff[1];
  wire chk_done_s = s2_ff[0];

  reg [8:0] prev_ff;
  always @(posedge core_clk) begin
    if (reset)
      prev_ff <= 9'h0;
    else
      prev_ff <= s2_ff;
  end
  wire [8:0] rise = s2_ff & ~prev_ff;

  // up key act pulse, repeating when the keyboard mode allows
  wire up_act;
  repeat_timer #(
    .REPEAT_CYCLES (REPEAT_CYCLES)
  ) u_rep (
    .core_clk  (core_clk),
    .reset     (reset),
    .key_level (up_s),
    .repeat_en (kb_mode_ff[`KB_REPEAT_BIT]),
    .act_pulse (up_act)
  );
  wire [3:0] step_val;
  wire       step_carry;
  digit_stepper u_step (
    .digit_in  (digit_ff),
    .carry_en  (kb_mode_ff[`KB_CARRY_BIT]),
    .digit_out (step_val),
    .carry_out (step_carry)
  );

  // power-up capture: third cycle after reset release
  reg        captured_ff;
  reg [1:0]  settle_ff;
  reg [2:0]  st_ff;
  reg [31:0] tmr_ff;
  reg        sel_armed_ff;
  reg        latch_ff;
  reg        pend_ff;
  reg [31:0] flt_cnt_ff;

  function [2:0] step_flt;
    input [2:0] m;
    begin
      if (m >= `FLT_MODE_MAX)
        step_flt = `FLT_MODE_MIN;
      else
        step_flt = m + 3'h1;
    end
  endfunction

  // decoders shared by capture and fault logic
  function is_selftest_addr;
    input [7:0] a;
    begin
      is_selftest_addr = (a == `ADDR_SELFTEST);
    end
  endfunction

  function low_range;
    input [1:0] r;
    begin
      low_range = (r == `RANGE_10MV) || (r == `RANGE_100MV);
    end
  endfunction

  wire detect_ok = !low_range(range_ff);
  wire ovl_act   = ovl_s && detect_ok && !selftest_ff;
  wire delay_hit = (flt_cnt_ff >= FAULT_DELAY_CYCLES - 1);

  always @(posedge core_clk) begin
    if (reset) begin
      captured_ff     <= 1'b0;
      settle_ff       <= 2'h0;
      addr_latched_ff <= 8'h0;
      selftest_ff     <= 1'b0;
      st_ff           <= ST_IDLE;
      tmr_ff          <= 32'h0;
      seg_lamp_ff     <= 6'h0;
      seg_lamp_on_ff  <= 1'b0;
      led_lamp_ff     <= 20'h0;
      pass_word_ff    <= 1'b0;
      error_word_ff   <= 1'b0;
      error_code_ff   <= `ERR_NONE;
      cal_erase_ff    <= 1'b0;
    end else begin
      // two settle cycles: both sync stages are cleared by reset
      settle_ff <= {settle_ff[0], 1'b1};
      if (settle_ff[`SW_SETTLE_BIT] && !captured_ff) begin
        captured_ff     <= 1'b1;
        addr_latched_ff <= sw2_ff;
        selftest_ff     <= is_selftest_addr(sw2_ff);
        st_ff           <= is_selftest_addr(sw2_ff) ? ST_SEG : ST_RUN;
        cal_erase_ff    <= is_selftest_addr(sw2_ff) && cal2_ff;
      end
      case (st_ff)
        ST_IDLE: ;
        ST_SEG: begin
          seg_lamp_on_ff <= 1'b1;
          if (tmr_ff == STEP_CYCLES - 1) begin
            tmr_ff <= 32'h0;
            if ({1'b0, seg_lamp_ff} == `SEG_COUNT - 7'h1) begin
              seg_lamp_on_ff <= 1'b0;
              st_ff          <= ST_LED;
              led_lamp_ff    <= ~`LED_UNTESTED;
            end else
              seg_lamp_ff <= seg_lamp_ff + 6'h1;
          end else
            tmr_ff <= tmr_ff + 32'h1;
        end
        ST_LED: begin
          // front-panel zero, fs, + and - leds are never lamped
          led_lamp_ff <= ~`LED_UNTESTED;
          if (tmr_ff == STEP_CYCLES - 1) begin
            tmr_ff      <= 32'h0;
            led_lamp_ff <= 20'h0;
            st_ff       <= ST_WAIT;
          end else
            tmr_ff <= tmr_ff + 32'h1;
        end
        ST_WAIT: begin
          if (chk_done_s) begin
            st_ff <= ST_DONE;
            if (code2_ff != `ERR_NONE) begin
              error_word_ff <= 1'b1;
              error_code_ff <= code2_ff;
            end else if (cal_bad_s && !cal_erase_ff) begin
              error_word_ff <= 1'b1;
              error_code_ff <= `ERR_CAL;
            end else
              pass_word_ff <= 1'b1;
          end
        end
        ST_DONE: ; // held until power cycle
        ST_RUN: begin
          if (cal_bad_s) begin
            error_word_ff <= 1'b1;
            error_code_ff <= `ERR_CAL;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // user-function menu and keyboard digit
  always @(posedge core_clk) begin
    if (reset) begin
      fn_display_ff  <= 1'b0;
      sel_armed_ff   <= 1'b0;
      kb_mode_ff     <= `KB_MODE_RESET;
      flt_mode_ff    <= `FLT_MODE_RESET;
      digit_ff       <= `DIGIT_ZERO;
      digit_carry_ff <= 1'b0;
      range_ff       <= `RANGE_10MV;
    end else begin
      digit_carry_ff <= 1'b0;
      if (rise[7])
        sel_armed_ff <= 1'b1;
      else if (rise[6])
        sel_armed_ff <= 1'b0;
      if (rise[6] && st_ff == ST_RUN)
        fn_display_ff <= sel_armed_ff ? 1'b1 : 1'b0;
      if (fn_display_ff) begin
        // only digit 6 and digit 8 arrows act
        if (rise[5])
          kb_mode_ff <= kb_mode_ff + 2'h1;
        if (rise[4])
          flt_mode_ff <= step_flt(flt_mode_ff);
      end else if (up_act && st_ff == ST_RUN) begin
        digit_ff       <= step_val;
        digit_carry_ff <= step_carry;
      end
      if (rise[2] && st_ff == ST_RUN) begin
        range_ff <= rg2_ff;
        if (!sel_armed_ff)
          digit_ff <= dig2_ff;
      end
    end
  end

  // output fault response
  always @(posedge core_clk) begin
    if (reset) begin
      output_zero_ff             <= 1'b1;
      output_fault_indication_ff <= 1'b0;
      latch_ff                   <= 1'b0;
      pend_ff                    <= 1'b0;
      flt_cnt_ff                 <= 32'h0;
    end else if (rise[2]) begin
      // reselect ends a latched fault and releases the output
      latch_ff                   <= 1'b0;
      pend_ff                    <= 1'b0;
      flt_cnt_ff                 <= 32'h0;
      output_zero_ff             <= 1'b0;
      output_fault_indication_ff <= 1'b0;
    end else if (st_ff == ST_RUN) begin
      case (flt_mode_ff)
        `FLT_MODE_IMM: begin
          if (ovl_act || latch_ff) begin
            latch_ff                   <= 1'b1;
            output_zero_ff             <= 1'b1;
            output_fault_indication_ff <= 1'b1;
          end
        end
        `FLT_MODE_AUTO: begin
          output_zero_ff             <= ovl_act;
          output_fault_indication_ff <= ovl_act;
        end
        `FLT_MODE_DELAY, `FLT_MODE_WARN: begin
          if (latch_ff) begin
            output_fault_indication_ff <= 1'b1;
            output_zero_ff <= (flt_mode_ff == `FLT_MODE_DELAY);
          end else if (ovl_act || pend_ff) begin
            pend_ff <= 1'b1;
            if (delay_hit) begin
              latch_ff                   <= 1'b1;
              output_fault_indication_ff <= 1'b1;
              output_zero_ff <= (flt_mode_ff == `FLT_MODE_DELAY);
            end else
              flt_cnt_ff <= flt_cnt_ff + 32'h1;
          end
        end
        default: output_fault_indication_ff <= 1'b0;
      endcase
    end
  end
endmodule

// >>> panel_control_assertions.sv
// port assertions for the panel control block
// assumes bind into panel_control, single clock domain
`timescale 1ns/1ps
module panel_control_checks #(
  parameter FAULT_DELAY_CYCLES = 20
) (
  input wire        core_clk,
  input wire        reset,
  input wire        overload_sense,
  input wire        fn_display_ff,
  input wire [1:0]  kb_mode_ff,
  input wire [2:0]  flt_mode_ff,
  input wire [3:0]  digit_ff,
  input wire        digit_carry_ff,
  input wire        output_zero_ff,
  input wire        output_fault_indication_ff,
  input wire [1:0]  range_ff,
  input wire        selftest_ff,
  input wire [19:0] led_lamp_ff,
  input wire [7:0]  addr_latched_ff
);
  reg [31:0] ovl_cnt_ff;
  // raw pin count; sync stages only lengthen the real wait
  always @(posedge core_clk)
    ovl_cnt_ff <= (reset || !overload_sense) ? 32'h0 : ovl_cnt_ff + 32'h1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_reset_modes: assert property (
    $fell(reset) |-> kb_mode_ff == 2'h3 && flt_mode_ff == 3'h1)
    else $error("modes not at reset values");
  chk_low_range: assert property (
    (range_ff < 2'h2) [*2] |-> !$rose(output_fault_indication_ff))
    else $error("fault raised on a low range");
  chk_kb_step: assert property (
    kb_mode_ff != $past(kb_mode_ff) |->
      $past(fn_display_ff) && kb_mode_ff == $past(kb_mode_ff) + 2'h1)
    else $error("keyboard mode stepped wrongly");
  chk_flt_step: assert property (
    flt_mode_ff != $past(flt_mode_ff) |-> flt_mode_ff ==
      ($past(flt_mode_ff) == 3'h4 ? 3'h1 : $past(flt_mode_ff) + 3'h1))
    else $error("fault mode stepped wrongly");
  chk_carry_out: assert property (
    digit_carry_ff |-> kb_mode_ff[0] && digit_ff == 4'h0)
    else $error("carry without carry mode");
  chk_fault_zero: assert property (
    $rose(output_fault_indication_ff) && flt_mode_ff != 3'h4
      |-> output_zero_ff)
    else $error("fault shown with output live");
  chk_warn_drive: assert property (
    flt_mode_ff == 3'h4 |-> !$rose(output_zero_ff))
    else $error("warn mode zeroed the output");
  chk_delay_wait: assert property (
    $rose(output_fault_indication_ff) && flt_mode_ff > 3'h2
      |-> ovl_cnt_ff >= FAULT_DELAY_CYCLES)
    else $error("delayed fault came early");
  chk_led_skip: assert property (
    led_lamp_ff[3:0] == 4'h0)
    else $error("untested lamp lit");
  chk_switch_hold: assert property (
    !$past(reset, 4) && !$past(reset, 3) && !$past(reset, 2)
      && !$past(reset) |-> $stable(addr_latched_ff))
    else $error("switches resampled");
  chk_self_hold: assert property (
    selftest_ff |=> selftest_ff)
    else $error("self-test left without power cycle");
  cover property ($rose(selftest_ff));
  cover property ($rose(digit_carry_ff));
  cover property ($rose(output_fault_indication_ff) && flt_mode_ff == 3'h3);
endmodule
bind panel_control panel_control_checks #(
  .FAULT_DELAY_CYCLES(FAULT_DELAY_CYCLES)
) i_chk (.*);

// >>> panel_control_tb.sv
// self-checking bench for the panel control block
// assumes the far-side model and the bound checker are compiled in
`timescale 1ns/1ps
module panel_control_tb;
  reg         core_clk = 1'b0;
  reg         reset = 1'b1;
  reg  [4:0]  keys = 5'h0;
  reg  [1:0]  range_sel = 2'h0;
  reg         reselect = 1'b0;
  reg         short_load = 1'b0;
  reg         corrupt_set = 1'b0;
  reg  [7:0]  addr_switch = 8'h05;
  reg         cal_key = 1'b0;
  reg  [2:0]  hw_fault_code = 3'h0;
  reg         selftest_checks_done = 1'b0;
  reg  [3:0]  set_digit = 4'h0;
  wire        overload_sense, cal_corrupt, fn_display_ff, digit_carry_ff;
  wire        output_zero_ff, output_fault_indication_ff, selftest_ff;
  wire        seg_lamp_on_ff, pass_word_ff, error_word_ff, cal_erase_ff;
  wire [1:0]  kb_mode_ff, range_ff;
  wire [2:0]  flt_mode_ff, error_code_ff;
  wire [3:0]  digit_ff;
  wire [5:0]  seg_lamp_ff;
  wire [19:0] led_lamp_ff;
  wire [7:0]  addr_latched_ff;
  integer     bad_count = 0, comparisons = 0, cyc = 0, i, m, n, chg, cy;
  reg  [5:0]  prev_seg;
  reg  [3:0]  prev_d;
  // short counts keep the run brief
  panel_control #(.FAULT_DELAY_CYCLES(20), .STEP_CYCLES(4),
    .REPEAT_CYCLES(4)) i_dut (
    .core_clk                   (core_clk),
    .reset                      (reset),
    .select_key                 (keys[0]),
    .deviation_key              (keys[1]),
    .arrow_kb_key               (keys[2]),
    .arrow_flt_key              (keys[3]),
    .up_key                     (keys[4]),
    .range_sel                  (range_sel),
    .reselect                   (reselect),
    .overload_sense             (overload_sense),
    .addr_switch                (addr_switch),
    .cal_key                    (cal_key),
    .cal_corrupt                (cal_corrupt),
    .hw_fault_code              (hw_fault_code),
    .selftest_checks_done       (selftest_checks_done),
    .set_digit                  (set_digit),
    .fn_display_ff              (fn_display_ff),
    .kb_mode_ff                 (kb_mode_ff),
    .flt_mode_ff                (flt_mode_ff),
    .digit_ff                   (digit_ff),
    .digit_carry_ff             (digit_carry_ff),
    .output_zero_ff             (output_zero_ff),
    .output_fault_indication_ff (output_fault_indication_ff),
    .range_ff                   (range_ff),
    .selftest_ff                (selftest_ff),
    .seg_lamp_ff                (seg_lamp_ff),
    .seg_lamp_on_ff             (seg_lamp_on_ff),
    .led_lamp_ff                (led_lamp_ff),
    .pass_word_ff               (pass_word_ff),
    .error_word_ff              (error_word_ff),
    .error_code_ff              (error_code_ff),
    .cal_erase_ff               (cal_erase_ff),
    .addr_latched_ff            (addr_latched_ff));
  panel_far_side i_far (
    .core_clk       (core_clk),
    .short_load     (short_load),
    .corrupt_set    (corrupt_set),
    .cal_erase_ff   (cal_erase_ff),
    .overload_sense (overload_sense),
    .cal_corrupt    (cal_corrupt));
  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      summarize;
    end
  end
  task summarize;
    begin
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wt(input integer c);
    repeat (c) @(negedge core_clk);
  endtask
  task press(input integer k, input integer h);
    begin
      keys[k] = 1'b1;
      wt(h);
      keys[k] = 1'b0;
      wt(8);
    end
  endtask
  task set_modes(input [1:0] kb, input [2:0] fl);
    begin
      press(0, 4);
      press(1, 4);
      cmp(fn_display_ff, 1'h1);
      for (i = 0; i < 4; i = i + 1)
        if (kb_mode_ff !== kb) press(2, 4);
      for (i = 0; i < 4; i = i + 1)
        if (flt_mode_ff !== fl) press(3, 4);
      cmp(kb_mode_ff, kb);
      cmp(flt_mode_ff, fl);
      press(1, 4);
      cmp(fn_display_ff, 1'h0);
    end
  endtask
  task resel(input [1:0] r, input [3:0] d);
    begin
      range_sel = r;
      set_digit = d;
      reselect = 1'b1;
      wt(6);
      reselect = 1'b0;
      wt(6);
    end
  endtask
  task pwr(input [7:0] a);
    begin
      addr_switch = a;
      reset = 1'b1;
      wt(16);
      reset = 1'b0;
    end
  endtask
  task selftest(input [2:0] code);
    begin
      pwr(8'hff);
      n = 0;
      for (i = 0; i < 1000 && led_lamp_ff === 20'h0; i = i + 1) begin
        if (seg_lamp_on_ff === 1'b1 && (n == 0 || seg_lamp_ff !== prev_seg))
          n = n + 1;
        prev_seg = seg_lamp_ff;
        wt(1);
      end
      cmp(n, 64);
      cmp(led_lamp_ff, 20'hffff0);
      cmp(selftest_ff, 1'h1);
      hw_fault_code = code;
      selftest_checks_done = 1'b1;
      wt(20);
      cmp(pass_word_ff, code == 3'h0);
      cmp(error_word_ff, code != 3'h0);
      cmp(error_code_ff, code);
      selftest_checks_done = 1'b0;
    end
  endtask
  initial begin
    wt(16);
    reset = 1'b0;
    wt(8);
    cmp(kb_mode_ff, 2'h3);
    cmp(flt_mode_ff, 3'h1);
    cmp(range_ff, 2'h0);
    cmp(output_zero_ff, 1'h1);
    addr_switch = 8'hff;
    wt(8);
    cmp(addr_latched_ff, 8'h05);
    cmp(selftest_ff, 1'h0);
    for (m = 0; m < 4; m = m + 1) begin
      set_modes(m[1:0], 3'h1);
      resel(2'h3, 4'h9);
      chg = 0;
      cy = 0;
      prev_d = digit_ff;
      keys[4] = 1'b1;
      for (n = 0; n < 40; n = n + 1) begin
        wt(1);
        if (digit_ff !== prev_d) chg = chg + 1;
        if (digit_carry_ff === 1'b1) cy = cy + 1;
        prev_d = digit_ff;
      end
      keys[4] = 1'b0;
      wt(8);
      cmp(cy != 0, m % 2);
      cmp(chg > 1, m > 1);
      if (m == 0) cmp(digit_ff, 4'h0);
    end
    for (m = 1; m < 5; m = m + 1) begin
      set_modes(2'h3, m[2:0]);
      resel(2'h3, 4'h5);
      cmp(output_zero_ff, 1'h0);
      short_load = 1'b1;
      wt(8);
      cmp(output_zero_ff, m < 3);
      cmp(output_fault_indication_ff, m < 3);
      wt(25);
      cmp(output_zero_ff, m != 4);
      cmp(output_fault_indication_ff, 1'h1);
      short_load = 1'b0;
      wt(8);
      cmp(output_zero_ff, m % 2);
      if (m != 4) cmp(output_fault_indication_ff, m % 2);
      resel(2'h3, 4'h5);
      cmp(output_fault_indication_ff, 1'h0);
    end
    resel(2'h1, 4'h5);
    short_load = 1'b1;
    wt(40);
    cmp(output_fault_indication_ff, 1'h0);
    short_load = 1'b0;
    corrupt_set = 1'b1;
    wt(2);
    corrupt_set = 1'b0;
    pwr(8'h05);
    wt(20);
    cmp(error_code_ff, 3'h6);
    cal_key = 1'b1;
    selftest(3'h0);
    cmp(cal_corrupt, 1'h0);
    cal_key = 1'b0;
    for (m = 1; m < 6; m = m + 1)
      if (m != 3) selftest(m[2:0]);
    // operator exit: power off, normal address, power on
    pwr(8'h05);
    wt(8);
    cmp(selftest_ff, 1'h0);
    summarize;
  end
endmodule

// >>> panel_far_side.sv
// far side model: output stage overload sense and calibration memory
// assumes the bench commands load shorts and memory corruption
`timescale 1ns/1ps
module panel_far_side (
  input  wire core_clk,
  input  wire short_load,
  input  wire corrupt_set,
  input  wire cal_erase_ff,
  output wire overload_sense,
  output reg  cal_corrupt
);
  // stage reports on every range; filtering is the block's job
  assign overload_sense = short_load;
  initial cal_corrupt = 1'b0;
  // non-volatile, so no reset: corruption survives power cycles
  always @(posedge core_clk)
    if (cal_erase_ff) cal_corrupt <= 1'b0;
    else if (corrupt_set) cal_corrupt <= 1'b1;
endmodule

// >>> panel_regs.vh
// constants for the front panel mode, fault and self-test logic
// assumes one 50 MHz clock and a synchronous active-high reset
// Function
// - select then deviation key opens the user-function display
// - display digits 2,4,6,7,8 shown; only digits 6 and 8 active
// - arrow under a function digit steps that mode up by one
// - keyboard mode: 0 none, 1 carry, 2 repeat, 3 both
// - carry mode carries past 9; otherwise the digit wraps 9 to 0
// - modes 2 and 3 repeat a held key; others act once per press
// - raise output fault indication when the output stage cannot drive
// - no fault detection on the 10mV and 100mV ranges
// - fault mode 1: zero at once, latch until output reselected
// - fault mode 2: zero at once, restore when overload clears
// - fault mode 3: after 0.5 s zero output, latch until reselected
// - fault mode 4: keep driving, show fault after 0.5 s
// - all eight address switches on at power-up runs self-test
// - self-test lights each segment, then LEDs except FS, zero, +, -
// - self-test with no fault shows the pass word
// - failure shows error word with code 1, 2, 4, 5 or 6
// - calibration memory check runs every power-up; code 6 if corrupt
// - self-test with calibration key inserted erases calibration memory
// - normal power-up selects the 10mV range with zero output
// - switches sampled only at power-up
`ifndef PANEL_REGS_VH
`define PANEL_REGS_VH
`define KB_MODE_RESET    2'h3
`define KB_MODE_MAX      2'h3
`define KB_MODE_MIN      2'h0
`define FLT_MODE_RESET   3'h1
`define FLT_MODE_MAX     3'h4
`define FLT_MODE_MIN     3'h1
`define FLT_MODE_IMM     3'h1
`define FLT_MODE_AUTO    3'h2
`define FLT_MODE_DELAY   3'h3
`define FLT_MODE_WARN    3'h4
`define KB_CARRY_BIT     0
`define KB_REPEAT_BIT    1
`define RANGE_10MV       2'h0
`define RANGE_100MV      2'h1
`define DIGIT_MAX        4'h9
`define DIGIT_ZERO       4'h0
`define FN_DIGIT_KB      4'h6
`define FN_DIGIT_FLT     4'h8
`define SW_SETTLE_BIT    1
`define ADDR_SELFTEST    8'hff
`define ERR_NONE         3'h0
`define ERR_RAM          3'h1
`define ERR_BUSCTL       3'h2
`define ERR_PORT_A       3'h4
`define ERR_PORT_B       3'h5
`define ERR_CAL          3'h6
`define FAULT_DELAY_MS   500
`define CLK_KHZ          50000
`define SEG_COUNT        7'h40
`define LED_COUNT        5'h14
`define LED_UNTESTED     20'h0000f
`endif

// >>> repeat_timer.v
// held-key repeat pulse generator
// assumes key level already synchronised to core_clk
`timescale 1ns/1ps
`include "panel_regs.vh"
module repeat_timer #(
  parameter REPEAT_CYCLES = 5000000
) (
  input  wire core_clk,
  input  wire reset,
  input  wire key_level,
  input  wire repeat_en,
  output reg  act_pulse
);
  reg [31:0] cnt_ff;
  reg        prev_ff;
  always @(posedge core_clk) begin
    if (reset) begin
      cnt_ff    <= 32'h0;
      prev_ff   <= 1'b0;
      act_pulse <= 1'b0;
    end else begin
      prev_ff <= key_level;
      if (key_level && !prev_ff) begin
        act_pulse <= 1'b1;
        cnt_ff    <= 32'h0;
      end else if (key_level && repeat_en) begin
        if (cnt_ff == REPEAT_CYCLES - 1) begin
          act_pulse <= 1'b1;
          cnt_ff    <= 32'h0;
        end else begin
          act_pulse <= 1'b0;
          cnt_ff    <= cnt_ff + 32'h1;
        end
      end else begin
        act_pulse <= 1'b0;
        cnt_ff    <= 32'h0;
      end
    end
  end
endmodule
